// [hw/pmbus_sync_and_ov_config.sv]
`timescale 1ns/1ps
`include "pmbus_sync_and_ov_config_regs.svh"

// How it works
// [RULE_01] stop threshold accepts 1 V to 80 V in 0.5 V steps, default f812h
// [RULE_02] out-of-range or off-grid stop threshold writes are dropped and flagged
// [RULE_03] conversion stops once input falls to the stop threshold after starting
// [RULE_04] stop threshold is linear11 with exponent fixed at minus one
// [RULE_05] sync selector has four legal settings: standalone, master, slave 0, slave 180
// [RULE_06] standalone uses resistor frequency, neither drives nor follows the sync pin
// [RULE_07] a bus frequency value overrides the resistor frequency once received
// [RULE_08] master drives a 50% pulse in phase once internal supply is good
// [RULE_09] slave in phase locks to the external sync pulse with no offset
// [RULE_10] slave anti-phase locks to the external sync pulse half a period shifted
// [RULE_11] sync selector defaults to master
// [RULE_12] illegal sync mode writes are dropped and flagged
// [RULE_13] overvoltage limit is a 16-bit unsigned value in output format units
// [RULE_14] overvoltage limit default is 0161h at 1.953 mV per count
// [RULE_15] overvoltage fault when sensed output exceeds the limit
// [RULE_16] 8-bit overvoltage action register, read/write, default f8h
// [RULE_17] action byte: response 7:6, retry 5:3, delay 2:0
// [RULE_18] a dropped write leaves every register unchanged
// [RULE_19] host writes legal and illegal values and checks readback or flags
module pmbus_sync_and_ov_config
   import pmbus_sync_and_ov_config_pkg::*;
#(
   parameter int LINK_KHZ = 20833
)(
   // clocks and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        link_clk,
   // command port from the bus transport
   input  wire cmd_t        cmd,
   input  wire logic        reject_clear,
   output logic [15:0]      rd_data_reg,
   output logic             rd_valid_reg,
   output logic             reject_pulse_reg,
   output logic             reject_sticky_reg,
   // measurements and converter control
   input  wire logic [15:0] rt_period,
   input  wire logic [10:0] vin_meas,
   input  wire logic [15:0] vout_meas,
   input  wire logic        run_request,
   output logic             converting_reg,
   output logic             ov_fault_reg,
   output ov_action_t       ov_action_reg,
   // internal supply good pin and sync pin
   input  wire logic        vdd_ok_pin,
   input  wire logic        freq_set_sync_pin_in,
   output logic             freq_set_sync_pin_out_reg,
   output logic             freq_set_sync_pin_oe_n_reg,
   output logic             sw_phase_reg
);

   function automatic logic [2:0] decode_mode(input logic [15:0] code);
      if (code == `CODE_STANDALONE)
         decode_mode = {1'b1, MODE_STANDALONE};
      else if (code == `CODE_MASTER)
         decode_mode = {1'b1, MODE_MASTER};
      else if (code == `CODE_SLAVE_0)
         decode_mode = {1'b1, MODE_SLAVE_0};
      else if (code == `CODE_SLAVE_180)
         decode_mode = {1'b1, MODE_SLAVE_180};
      else
         decode_mode = {1'b0, MODE_STANDALONE};
   endfunction

   logic [1:0]  rst_pipe;
   logic        rst_sync_n;
   logic [15:0] stop_thr_reg;
   logic [15:0] mode_code_reg;
   logic [15:0] ov_limit_reg;
   logic [15:0] freq_reg;
   logic        freq_override_reg;
   logic        wr;
   logic        stop_ok;
   logic        mode_ok;
   logic        freq_ok;
   logic        bad_write;
   logic [2:0]  mode_dec;
   logic [2:0]  mode_cur;
   logic [31:0] div_q;
   logic [15:0] period_sel;
   link_word_t  word_next;
   link_word_t  shadow_reg;
   logic        req_reg;
   logic [1:0]  ack_sync;
   logic        ack_l_reg;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe <= 2'b00;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_sync_n = rst_pipe[1];

   assign wr = cmd.valid && cmd.write;
   // exponent pinned at -1, mantissa counts half volts
   assign stop_ok = (cmd.data[`L11_EXP_MSB:`L11_EXP_LSB] == `STOP_EXP) && // RULE_04
                    (cmd.data[`L11_MAN_MSB:0] >= `STOP_MAN_MIN) &&
                    (cmd.data[`L11_MAN_MSB:0] <= `STOP_MAN_MAX);
   assign mode_dec = decode_mode(cmd.data);
   assign mode_ok = mode_dec[2];
   assign freq_ok = (cmd.data[`L11_EXP_MSB:`L11_EXP_LSB] == `FREQ_EXP) &&
                    (cmd.data[`L11_MAN_MSB:0] >= `FREQ_MIN_KHZ) &&
                    (cmd.data[`L11_MAN_MSB:0] <= `FREQ_MAX_KHZ) &&
                    ((cmd.data[`L11_MAN_MSB:0] % `FREQ_STEP_KHZ) == 11'h000);

   always_comb
   begin
      if (cmd.code == `CMD_INPUT_STOP)
         bad_write = wr && !stop_ok; // RULE_02
      else if (cmd.code == `CMD_SYNC_MODE)
         bad_write = wr && !mode_ok; // RULE_12
      else if (cmd.code == `CMD_FREQ_SWITCH)
         bad_write = wr && !freq_ok;
      else if (cmd.code == `CMD_OV_LIMIT || cmd.code == `CMD_OV_ACTION)
         bad_write = 1'b0;
      else
         bad_write = cmd.valid;
   end

   // each register loads only on its own accepted write
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         stop_thr_reg      <= `RST_INPUT_STOP; // RULE_01
         mode_code_reg     <= `RST_SYNC_MODE; // RULE_11
         ov_limit_reg      <= `RST_OV_LIMIT; // RULE_14
         ov_action_reg     <= `RST_OV_ACTION; // RULE_16
         freq_reg          <= `RST_FREQ_SWITCH;
         freq_override_reg <= 1'b0;
      end
      else if (wr && !bad_write) // RULE_18
      begin
         if (cmd.code == `CMD_INPUT_STOP)
            stop_thr_reg <= cmd.data; // RULE_01
         else if (cmd.code == `CMD_SYNC_MODE)
            mode_code_reg <= cmd.data; // RULE_05
         else if (cmd.code == `CMD_OV_LIMIT)
            ov_limit_reg <= cmd.data; // RULE_13
         else if (cmd.code == `CMD_OV_ACTION)
            ov_action_reg <= cmd.data[7:0]; // RULE_17
         else if (cmd.code == `CMD_FREQ_SWITCH)
         begin
            freq_reg          <= cmd.data;
            freq_override_reg <= 1'b1; // RULE_07
         end
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         rd_data_reg  <= 16'h0000;
         rd_valid_reg <= 1'b0;
      end
      else
      begin
         rd_valid_reg <= cmd.valid && !cmd.write && !bad_write;
         if (cmd.code == `CMD_INPUT_STOP)
            rd_data_reg <= stop_thr_reg;
         else if (cmd.code == `CMD_SYNC_MODE)
            rd_data_reg <= mode_code_reg;
         else if (cmd.code == `CMD_OV_LIMIT)
            rd_data_reg <= ov_limit_reg;
         else if (cmd.code == `CMD_OV_ACTION)
            rd_data_reg <= {8'h00, ov_action_reg};
         else if (cmd.code == `CMD_FREQ_SWITCH)
            rd_data_reg <= freq_reg;
         else
            rd_data_reg <= 16'h0000;
      end
   end

   // set wins over clear so a reject in the clearing cycle is kept
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         reject_pulse_reg  <= 1'b0;
         reject_sticky_reg <= 1'b0;
      end
      else
      begin
         reject_pulse_reg <= bad_write; // RULE_02
         if (bad_write)
            reject_sticky_reg <= 1'b1; // RULE_12
         else if (reject_clear)
            reject_sticky_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         converting_reg <= 1'b0;
         ov_fault_reg   <= 1'b0;
      end
      else
      begin
         if (converting_reg && vin_meas <= stop_thr_reg[`L11_MAN_MSB:0])
            converting_reg <= 1'b0; // RULE_03
         else if (run_request && vin_meas > stop_thr_reg[`L11_MAN_MSB:0])
            converting_reg <= 1'b1;
         else if (!run_request)
            converting_reg <= 1'b0;
         ov_fault_reg <= vout_meas > ov_limit_reg; // RULE_15
      end
   end

   // bus frequency in kHz turned into link clock cycles
   assign div_q = LINK_KHZ / {21'd0, freq_reg[`L11_MAN_MSB:0]};
   assign period_sel = freq_override_reg ? div_q[15:0] : rt_period; // RULE_07
   assign mode_cur = decode_mode(mode_code_reg);
   assign word_next.mode = sync_mode_t'(mode_cur[1:0]);
   assign word_next.period = (period_sel < `MIN_PERIOD) ? `MIN_PERIOD : period_sel;

   // toggle handshake: shadow is only changed once the link side has taken it
   always_ff @(posedge clock or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         ack_sync   <= 2'b00;
         req_reg    <= 1'b0;
         shadow_reg <= {MODE_MASTER, `MIN_PERIOD};
      end
      else
      begin
         ack_sync <= {ack_sync[0], ack_l_reg};
         if (ack_sync[1] == req_reg && word_next != shadow_reg)
         begin
            shadow_reg <= word_next;
            req_reg    <= ~req_reg;
         end
      end
   end

   // link clock domain
   logic [1:0]  lrst_pipe;
   logic        lrst_n;
   logic [1:0]  req_l_sync;
   logic        req_l_seen;
   link_word_t  word_l_reg;
   logic [1:0]  vdd_l_sync;
   logic [1:0]  sync_in_l;
   logic        sync_prev_l;
   logic        sync_rise_l;
   logic [15:0] cnt_l_reg;

   always_ff @(posedge link_clk or negedge rst_n)
   begin
      if (!rst_n)
         lrst_pipe <= 2'b00;
      else
         lrst_pipe <= {lrst_pipe[0], 1'b1};
   end
   assign lrst_n = lrst_pipe[1];

   always_ff @(posedge link_clk or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         req_l_sync <= 2'b00;
         req_l_seen <= 1'b0;
         ack_l_reg  <= 1'b0;
         word_l_reg <= {MODE_MASTER, `MIN_PERIOD};
      end
      else
      begin
         req_l_sync <= {req_l_sync[0], req_reg};
         req_l_seen <= req_l_sync[1];
         if (req_l_sync[1] != req_l_seen)
         begin
            word_l_reg <= shadow_reg;
            ack_l_reg  <= req_l_sync[1];
         end
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         vdd_l_sync  <= 2'b00;
         sync_in_l   <= 2'b00;
         sync_prev_l <= 1'b0;
      end
      else
      begin
         vdd_l_sync  <= {vdd_l_sync[0], vdd_ok_pin};
         sync_in_l   <= {sync_in_l[0], freq_set_sync_pin_in};
         sync_prev_l <= sync_in_l[1];
      end
   end
   // standalone and master ignore the pin
   assign sync_rise_l = sync_in_l[1] && !sync_prev_l &&
                        (word_l_reg.mode == MODE_SLAVE_0 || word_l_reg.mode == MODE_SLAVE_180);

   always_ff @(posedge link_clk or negedge lrst_n)
   begin
      if (!lrst_n)
         cnt_l_reg <= 16'h0000;
      else if (sync_rise_l && word_l_reg.mode == MODE_SLAVE_0)
         cnt_l_reg <= 16'h0000; // RULE_09
      else if (sync_rise_l)
         cnt_l_reg <= {1'b0, word_l_reg.period[15:1]}; // RULE_10
      else if (cnt_l_reg >= word_l_reg.period - 16'h0001)
         cnt_l_reg <= 16'h0000;
      else
         cnt_l_reg <= cnt_l_reg + 16'h0001;
   end

   always_ff @(posedge link_clk or negedge lrst_n)
   begin
      if (!lrst_n)
      begin
         sw_phase_reg               <= 1'b0;
         freq_set_sync_pin_out_reg  <= 1'b0;
         freq_set_sync_pin_oe_n_reg <= 1'b1;
      end
      else
      begin
         sw_phase_reg <= cnt_l_reg < {1'b0, word_l_reg.period[15:1]};
         case (word_l_reg.mode)
            MODE_MASTER:
            begin
               freq_set_sync_pin_out_reg  <= cnt_l_reg < {1'b0, word_l_reg.period[15:1]};
               freq_set_sync_pin_oe_n_reg <= !vdd_l_sync[1]; // RULE_08
            end
            default:
            begin
               freq_set_sync_pin_out_reg  <= 1'b0;
               freq_set_sync_pin_oe_n_reg <= 1'b1; // RULE_06
            end
         endcase
      end
   end

   AST_STOP_ACCEPT: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_01
      wr && cmd.code == `CMD_INPUT_STOP && stop_ok |=> stop_thr_reg == $past(cmd.data))
      else $error("stop threshold write not stored");
   AST_STOP_REJECT: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_02
      wr && cmd.code == `CMD_INPUT_STOP && !stop_ok |=> $stable(stop_thr_reg) && reject_pulse_reg)
      else $error("bad stop threshold write not dropped and flagged");
   AST_STOP_EXP: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_04
      stop_thr_reg[`L11_EXP_MSB:`L11_EXP_LSB] == `STOP_EXP)
      else $error("stop threshold exponent not minus one");
   AST_CONV_STOP: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_03
      converting_reg && vin_meas <= stop_thr_reg[`L11_MAN_MSB:0] |=> !converting_reg)
      else $error("conversion continued below stop threshold");
   AST_MODE_LEGAL: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_05
      mode_cur[2])
      else $error("sync selector holds an illegal code");
   AST_MODE_REJECT: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_12
      wr && cmd.code == `CMD_SYNC_MODE && !mode_ok |=> $stable(mode_code_reg) && reject_sticky_reg)
      else $error("illegal sync mode write not dropped and flagged");
   AST_FREQ_OVR: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_07
      wr && cmd.code == `CMD_FREQ_SWITCH && freq_ok |=> freq_override_reg && period_sel == div_q[15:0])
      else $error("bus frequency did not override resistor");
   AST_OV_FAULT: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_15
      vout_meas > ov_limit_reg |=> ov_fault_reg)
      else $error("overvoltage not declared");
   AST_OV_ACTION: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_16
      wr && cmd.code == `CMD_OV_ACTION |=> ov_action_reg == $past(cmd.data[7:0]))
      else $error("action byte write not stored");
   AST_MASTER_DRIVE: assert property (@(posedge link_clk) disable iff (!lrst_n) // RULE_08
      word_l_reg.mode == MODE_MASTER && vdd_l_sync[1] |=> !freq_set_sync_pin_oe_n_reg)
      else $error("master not driving sync pin");
   AST_STANDALONE_FLOAT: assert property (@(posedge link_clk) disable iff (!lrst_n) // RULE_06
      word_l_reg.mode == MODE_STANDALONE |=> freq_set_sync_pin_oe_n_reg)
      else $error("standalone driving sync pin");
   AST_SLAVE0_LOCK: assert property (@(posedge link_clk) disable iff (!lrst_n) // RULE_09
      sync_rise_l && word_l_reg.mode == MODE_SLAVE_0 |=> cnt_l_reg == 16'h0000)
      else $error("in-phase slave did not lock");
   AST_SLAVE180_LOCK: assert property (@(posedge link_clk) disable iff (!lrst_n) // RULE_10
      sync_rise_l && word_l_reg.mode == MODE_SLAVE_180 && $stable(word_l_reg)
      |=> cnt_l_reg == {1'b0, word_l_reg.period[15:1]})
      else $error("anti-phase slave did not lock half a period shifted");

   COV_REJECT: cover property (@(posedge clock) disable iff (!rst_sync_n) reject_pulse_reg);
   COV_STOP: cover property (@(posedge clock) disable iff (!rst_sync_n)
      converting_reg ##1 !converting_reg);
   COV_SLAVE: cover property (@(posedge link_clk) disable iff (!lrst_n)
      sync_rise_l && word_l_reg.mode == MODE_SLAVE_180);

endmodule // pmbus_sync_and_ov_config

// [hw/pmbus_sync_and_ov_config_regs.svh]
`ifndef PMBUS_SYNC_AND_OV_CONFIG_REGS_SVH
`define PMBUS_SYNC_AND_OV_CONFIG_REGS_SVH

// command codes
`define CMD_FREQ_SWITCH         8'h33
`define CMD_INPUT_STOP          8'h36
`define CMD_SYNC_MODE           8'h37
`define CMD_OV_LIMIT            8'h40
`define CMD_OV_ACTION           8'h41

// stored defaults
`define RST_INPUT_STOP          16'hf812
`define RST_SYNC_MODE           16'h0100
`define RST_OV_LIMIT            16'h0161
`define RST_OV_ACTION           8'hf8
`define RST_FREQ_SWITCH         16'h0258

// legal sync mode codes
`define CODE_STANDALONE         16'h0000
`define CODE_MASTER             16'h0100
`define CODE_SLAVE_0            16'h0120
`define CODE_SLAVE_180          16'h0121

// linear11 fields and limits
`define L11_EXP_MSB             15
`define L11_EXP_LSB             11
`define L11_MAN_MSB             10
`define STOP_EXP                5'h1f
`define STOP_MAN_MIN            11'h002
`define STOP_MAN_MAX            11'h0a0
`define FREQ_EXP                5'h00
`define FREQ_MIN_KHZ            11'h12c
`define FREQ_MAX_KHZ            11'h5dc
`define FREQ_STEP_KHZ           11'h032

// overvoltage action fields
`define OVA_RESP_MSB            7
`define OVA_RESP_LSB            6
`define OVA_RETRY_MSB           5
`define OVA_RETRY_LSB           3
`define OVA_DELAY_MSB           2
`define OVA_DELAY_LSB           0

// switching generator
`define MIN_PERIOD              16'h0002

`endif

// [hw/pmbus_sync_and_ov_config_pkg.sv]
package pmbus_sync_and_ov_config_pkg;

   typedef enum logic [1:0] {
      MODE_STANDALONE = 2'b00,
      MODE_MASTER     = 2'b01,
      MODE_SLAVE_0    = 2'b10,
      MODE_SLAVE_180  = 2'b11
   } sync_mode_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } cmd_t;

   typedef struct packed {
      logic [1:0] response;
      logic [2:0] ov_retry_field;
      logic [2:0] ov_delay_field;
   } ov_action_t;

   typedef struct packed {
      sync_mode_t  mode;
      logic [15:0] period;
   } link_word_t;

endpackage

// [dv/pmbus_host_model.sv]
`timescale 1ns/1ps
module pmbus_host_model
   import pmbus_sync_and_ov_config_pkg::*;
(
   // command side
   input  wire logic        clock,
   output cmd_t             cmd,
   // answer side
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_valid,
   input  wire logic        reject_pulse
);
   initial cmd = '0;

   // one command per call, taken at the rising edge between the two falling edges;
   // the answer pulses stand one cycle, so they are sampled at the second falling edge
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                       output logic [15:0] rdata, output logic rv, output logic rj);
      @(negedge clock);
      cmd <= '{valid: 1'b1, write: wr, code: code, data: data};
      @(negedge clock);
      rdata = rd_data;
      rv    = rd_valid;
      rj    = reject_pulse;
      // released fields carry the inverse so a stale value never looks like a hold
      cmd <= '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
   endtask
endmodule // pmbus_host_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import pmbus_sync_and_ov_config_pkg::*;

   typedef struct packed {
      logic        wr;
      logic [7:0]  code;
      logic [15:0] data;
      logic        rej;
      logic [15:0] exp;
   } row_t;

   localparam row_t ROWS [24] = '{
      '{1'b0, 8'h36, 16'h0000, 1'b0, 16'hf812}, '{1'b0, 8'h37, 16'h0000, 1'b0, 16'h0100},
      '{1'b0, 8'h40, 16'h0000, 1'b0, 16'h0161}, '{1'b0, 8'h41, 16'h0000, 1'b0, 16'h00f8},
      '{1'b0, 8'h33, 16'h0000, 1'b0, 16'h0258}, '{1'b1, 8'h36, 16'hf814, 1'b0, 16'hf814},
      '{1'b1, 8'h36, 16'hf801, 1'b1, 16'hf814}, '{1'b1, 8'h36, 16'hf8a1, 1'b1, 16'hf814},
      '{1'b1, 8'h36, 16'hf0a0, 1'b1, 16'hf814}, '{1'b1, 8'h36, 16'hf8a0, 1'b0, 16'hf8a0},
      '{1'b1, 8'h36, 16'hf814, 1'b0, 16'hf814}, '{1'b1, 8'h37, 16'h0000, 1'b0, 16'h0000},
      '{1'b1, 8'h37, 16'h0120, 1'b0, 16'h0120}, '{1'b1, 8'h37, 16'h0121, 1'b0, 16'h0121},
      '{1'b1, 8'h37, 16'h0101, 1'b1, 16'h0121}, '{1'b1, 8'h37, 16'h0200, 1'b1, 16'h0121},
      '{1'b1, 8'h37, 16'h0100, 1'b0, 16'h0100}, '{1'b1, 8'h40, 16'hffff, 1'b0, 16'hffff},
      '{1'b1, 8'h40, 16'h0200, 1'b0, 16'h0200}, '{1'b1, 8'h41, 16'h00a5, 1'b0, 16'h00a5},
      '{1'b1, 8'h33, 16'h0145, 1'b1, 16'h0258}, '{1'b1, 8'h33, 16'h05dc, 1'b0, 16'h05dc},
      '{1'b1, 8'h33, 16'h05e6, 1'b1, 16'h05dc}, '{1'b0, 8'h50, 16'h0000, 1'b1, 16'h0000}
   };

   logic        clock;
   logic        rst_n;
   logic        link_clk;
   cmd_t        cmd;
   logic        reject_clear;
   logic [15:0] rd_data_reg;
   logic        rd_valid_reg;
   logic        reject_pulse_reg;
   logic        reject_sticky_reg;
   logic [15:0] rt_period;
   logic [10:0] vin_meas;
   logic [15:0] vout_meas;
   logic        run_request;
   logic        converting_reg;
   logic        ov_fault_reg;
   ov_action_t  ov_action_reg;
   logic        vdd_ok_pin;
   logic        ext_level;
   logic        sync_line;
   logic        freq_set_sync_pin_out_reg;
   logic        freq_set_sync_pin_oe_n_reg;
   logic        sw_phase_reg;
   int          err_count;
   int          n_tests;

   // when nobody drives the pin the line follows ext_level, the external sync source
   assign sync_line = (freq_set_sync_pin_oe_n_reg === 1'b0) ? freq_set_sync_pin_out_reg
                                                            : ext_level;

   pmbus_sync_and_ov_config #(.LINK_KHZ(20833)) pmbus_sync_and_ov_config_inst (
      .clock(clock), .rst_n(rst_n), .link_clk(link_clk), .cmd(cmd),
      .reject_clear(reject_clear), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg),
      .reject_pulse_reg(reject_pulse_reg), .reject_sticky_reg(reject_sticky_reg),
      .rt_period(rt_period), .vin_meas(vin_meas), .vout_meas(vout_meas),
      .run_request(run_request), .converting_reg(converting_reg),
      .ov_fault_reg(ov_fault_reg), .ov_action_reg(ov_action_reg), .vdd_ok_pin(vdd_ok_pin),
      .freq_set_sync_pin_in(sync_line),
      .freq_set_sync_pin_out_reg(freq_set_sync_pin_out_reg),
      .freq_set_sync_pin_oe_n_reg(freq_set_sync_pin_oe_n_reg), .sw_phase_reg(sw_phase_reg));

   pmbus_host_model pmbus_host_model_inst (
      .clock(clock), .cmd(cmd), .rd_data(rd_data_reg), .rd_valid(rd_valid_reg),
      .reject_pulse(reject_pulse_reg));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #24 link_clk = ~link_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic xfer_chk(input logic wr, input logic [7:0] code, input logic [15:0] data,
                           input logic rej, input logic [15:0] exp);
      logic [15:0] rdata;
      logic        rv;
      logic        rj;
      pmbus_host_model_inst.xfer(wr, code, data, rdata, rv, rj);
      check(16'(rj), 16'(rej));
      if (wr)
         pmbus_host_model_inst.xfer(1'b0, code, 16'h0000, rdata, rv, rj);
      check(16'(rv), 16'(!(rej && !wr)));
      if (wr || !rej)
         check(rdata, exp);
   endtask

   // period and high time of the driven pin, in link cycles, sampled mid-cycle
   task automatic meas(output int per, output int hi);
      logic prev;
      logic cur;
      int   k;
      prev = 1'b1;
      for (k = 0; k < 300; k++)
      begin
         @(negedge link_clk);
         cur = freq_set_sync_pin_out_reg;
         if (cur === 1'b1 && prev === 1'b0)
            break;
         prev = cur;
      end
      hi = 1;
      prev = 1'b1;
      for (per = 1; per < 300; per++)
      begin
         @(negedge link_clk);
         cur = freq_set_sync_pin_out_reg;
         if (cur === 1'b1 && prev === 1'b0)
            break;
         hi += (cur === 1'b1);
         prev = cur;
      end
   endtask

   task automatic slave_run(input logic [15:0] code, input logic exp_hi);
      xfer_chk(1'b1, 8'h37, code, 1'b0, code);
      repeat (20) @(negedge link_clk);
      check(16'(freq_set_sync_pin_oe_n_reg), 16'h0001);
      repeat (4)
      begin
         @(negedge link_clk);
         ext_level = 1'b1;
         repeat (8) @(negedge link_clk);
         check(16'(sw_phase_reg), 16'(exp_hi));
         repeat (5) @(negedge link_clk);
         ext_level = 1'b0;
         repeat (13) @(negedge link_clk);
      end
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      err_count++;
      conclude();
   end

   initial
   begin
      int per;
      int hi;
      err_count = 0;
      n_tests = 0;
      rst_n = 1'b0;
      reject_clear = 1'b0;
      rt_period = 16'h0014;
      vin_meas = 11'h000;
      vout_meas = 16'h0000;
      run_request = 1'b0;
      vdd_ok_pin = 1'b1;
      ext_level = 1'b0;
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      foreach (ROWS[i])
         xfer_chk(ROWS[i].wr, ROWS[i].code, ROWS[i].data, ROWS[i].rej, ROWS[i].exp);
      check(16'({ov_action_reg.response, ov_action_reg.ov_retry_field,
                 ov_action_reg.ov_delay_field}), 16'h00a5);
      check(16'(reject_sticky_reg), 16'h0001);
      @(negedge clock);
      reject_clear = 1'b1;
      @(negedge clock);
      reject_clear = 1'b0;
      @(negedge clock);
      check(16'(reject_sticky_reg), 16'h0000);
      // limit is 0200h: equal is no fault, one count above is
      vout_meas = 16'h0200;
      repeat (3) @(negedge clock);
      check(16'(ov_fault_reg), 16'h0000);
      vout_meas = 16'h0201;
      repeat (3) @(negedge clock);
      check(16'(ov_fault_reg), 16'h0001);
      // stop threshold f814h is 20 half-volts
      vin_meas = 11'd30;
      run_request = 1'b1;
      repeat (4) @(negedge clock);
      check(16'(converting_reg), 16'h0001);
      vin_meas = 11'd21;
      repeat (4) @(negedge clock);
      check(16'(converting_reg), 16'h0001);
      vin_meas = 11'd20;
      repeat (4) @(negedge clock);
      check(16'(converting_reg), 16'h0000);
      // master with the bus frequency of 1500 kHz overriding the resistor
      vdd_ok_pin = 1'b0;
      repeat (10) @(negedge link_clk);
      check(16'(freq_set_sync_pin_oe_n_reg), 16'h0001);
      vdd_ok_pin = 1'b1;
      repeat (10) @(negedge link_clk);
      check(16'(freq_set_sync_pin_oe_n_reg), 16'h0000);
      meas(per, hi);
      check(16'(per), 16'(20833 / 1500));
      check(16'(hi), 16'(20833 / 1500 / 2));
      xfer_chk(1'b1, 8'h37, 16'h0000, 1'b0, 16'h0000);
      repeat (20) @(negedge link_clk);
      check(16'(freq_set_sync_pin_oe_n_reg), 16'h0001);
      slave_run(16'h0120, 1'b1);
      slave_run(16'h0121, 1'b0);
      // second reset in mid-run: defaults come back and the override is gone
      @(negedge clock);
      rst_n = 1'b0;
      repeat (16) @(negedge clock);
      check(16'(freq_set_sync_pin_oe_n_reg), 16'h0001);
      check(16'(ov_action_reg), 16'h00f8);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      xfer_chk(1'b0, 8'h37, 16'h0000, 1'b0, 16'h0100);
      xfer_chk(1'b0, 8'h36, 16'h0000, 1'b0, 16'hf812);
      meas(per, hi);
      check(16'(per), 16'h0014);
      check(16'(hi), 16'h000a);
      conclude();
   end
endmodule // testbench
